/* File: fpc_consts.vh */
`ifndef FPC_CONSTS_VH
`define FPC_CONSTS_VH
// ----------------------------------------
// register indices (byte address = 4*index)
// ----------------------------------------
`define FPC_IDX_CMD_INDEX 6'h02
`define FPC_IDX_STATUS    6'h06
`define FPC_IDX_PFPROT    6'h08
`define FPC_IDX_EEPROT    6'h09
`define FPC_IDX_OPTION    6'h0a
`define FPC_IDX_RSV1      6'h0b
`define FPC_IDX_CMD_BASE  6'h0c
`define FPC_CMD_WORDS     6
// ----------------------------------------
// field positions
// ----------------------------------------
`define FPC_ST_COMMAND_COMPLETE_FLAG       7
`define FPC_ST_PVIOL      4
`define FPC_PF_OPEN       7
`define FPC_PF_HDIS       5
`define FPC_PF_HS_HI      4
`define FPC_PF_HS_LO      3
`define FPC_PF_LDIS       2
`define FPC_PF_LS_HI      1
`define FPC_PF_LS_LO      0
`define FPC_EE_OPEN       7
`define FPC_EE_SIZE_HI    5
// ----------------------------------------
// reset values, fault values and write masks
// ----------------------------------------
`define FPC_PF_RESET      8'hbf
`define FPC_PF_FAULT      8'h3f
`define FPC_EE_RESET      8'h80
`define FPC_EE_FAULT      8'h3f
`define FPC_OPT_RESET     8'hff
`define FPC_OPT_FAULT     8'hff
`define FPC_PF_WMASK      8'hbf
`define FPC_EE_WMASK      8'hbf
// ----------------------------------------
// eeprom protection granule
// ----------------------------------------
`define FPC_EE_STEP_LOG2  5
`endif

/* File: fpc_flash_prot.v */
// Our own choice: register access over APB.
`timescale 1ns/10ps
`include "fpc_consts.vh"
module fpc_flash_prot
#(
   parameter AW  = 8,
   parameter EAW = 11
)
(
   // apb
   input  wire            pclk,
   input  wire            presetn,
   input  wire            psel,
   input  wire            penable,
   input  wire            pwrite,
   input  wire [AW-1:0]   paddr,
   input  wire [31:0]     pwdata,
   input  wire [3:0]      pstrb,
   output wire            pready,
   output reg  [31:0]     prdata,
   output wire            pslverr,
   // mode and reset-sequence load
   input  wire            special_mode,
   input  wire            nvm_load,
   input  wire [7:0]      nvm_pflash_byte,
   input  wire            nvm_pflash_fault,
   input  wire [7:0]      nvm_eeprom_byte,
   input  wire            nvm_eeprom_fault,
   input  wire [7:0]      nvm_option_byte,
   input  wire            nvm_option_fault,
   // command controller
   output reg             cmd_launch,
   input  wire            cmd_done,
   input  wire            res_we,
   input  wire [2:0]      res_word,
   input  wire [15:0]     res_data,
   output wire [95:0]     cmd_words,
   output wire [7:0]      command_code,
   output wire [23:0]     cmd_address,
   output wire [2:0]      command_word_index,
   // eeprom program/erase check
   input  wire            ee_req,
   input  wire            ee_block_erase,
   input  wire [EAW-1:0]  ee_addr,
   output wire            ee_reject,
   // protection state and command complete flag
   output wire [2:0]      pflash_scenario,
   output wire            pflash_full_prot,
   output wire [7:0]      option_bits,
   output wire            command_complete_flag
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   reg  [7:0]   pflash_protect_reg_r;
   reg  [7:0]   pflash_protect_reg_nxt;
   reg  [7:0]   eeprom_protect_reg_r;
   reg  [7:0]   eeprom_protect_reg_nxt;
   reg  [7:0]   flash_option_reg_r;
   reg  [2:0]   command_index_reg_r;
   reg          command_complete_flag_r;
   reg          pviol_r;
   reg  [15:0]  cmd_word_r [0:`FPC_CMD_WORDS-1];

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire [5:0]   idx;
   wire         acc;
   wire         wr_acc;
   wire         mapped;
   wire         is_cmd;
   wire [5:0]   cmd_off;
   wire         hit_index;
   wire         hit_status;
   wire         hit_pf;
   wire         hit_ee;
   wire         hit_option;
   wire         hit_rsv;
   wire         wr_index;
   wire         wr_pf;
   wire         wr_ee;

   assign idx        = paddr[7:2];
   assign cmd_off    = idx - `FPC_IDX_CMD_BASE;
   assign is_cmd     = (idx >= `FPC_IDX_CMD_BASE) && (cmd_off < `FPC_CMD_WORDS);
   assign hit_index  = (idx == `FPC_IDX_CMD_INDEX);
   assign hit_status = (idx == `FPC_IDX_STATUS);
   assign hit_pf     = (idx == `FPC_IDX_PFPROT);
   assign hit_ee     = (idx == `FPC_IDX_EEPROT);
   assign hit_option = (idx == `FPC_IDX_OPTION);
   assign hit_rsv    = (idx == `FPC_IDX_RSV1);
   assign mapped     = is_cmd | hit_index | hit_status | hit_pf | hit_ee | hit_option | hit_rsv;
   // zero wait states: every access phase completes
   assign pready     = penable;
   assign acc        = psel & penable;
   assign pslverr    = acc & ~mapped;
   assign wr_acc     = acc & pwrite & mapped;
   // byte registers sit on lane 0 only
   assign wr_index   = wr_acc & hit_index & pstrb[0];
   assign wr_pf      = wr_acc & hit_pf & pstrb[0];
   assign wr_ee      = wr_acc & hit_ee & pstrb[0];

   // ----------------------------------------
   // program-flash protection
   // ----------------------------------------
   wire [2:0]   pf_cur;
   wire [2:0]   pf_new;
   wire [7:0]   pf_wr;
   reg  [7:0]   pf_allow;
   wire         pf_open_b;
   wire         pf_hdis_b;
   wire         pf_ldis_b;

   assign pf_wr     = pwdata[7:0] & `FPC_PF_WMASK;
   assign pf_open_b = pflash_protect_reg_r[`FPC_PF_OPEN];
   assign pf_hdis_b = pflash_protect_reg_r[`FPC_PF_HDIS];
   assign pf_ldis_b = pflash_protect_reg_r[`FPC_PF_LDIS];
   assign pf_cur    = {pf_open_b, pf_hdis_b, pf_ldis_b};
   assign pf_new    = {pf_wr[`FPC_PF_OPEN], pf_wr[`FPC_PF_HDIS], pf_wr[`FPC_PF_LDIS]};

   // ----------------------------------------
   // scenario transition table
   // ----------------------------------------
   // scenario code {open, hdis, ldis}
   //   7: nothing protected
   //   6: low range protected
   //   5: high range protected
   //   4: high and low ranges protected
   //   3: whole array protected
   //   2: all but the low range protected
   //   1: all but the high range protected
   //   0: all but both ranges protected
   // bit k set: move to scenario k allowed
   always @*
   begin
      case (pf_cur)
         3'h0: pf_allow = 8'h0f;
         3'h1: pf_allow = 8'h0a;
         3'h2: pf_allow = 8'h0c;
         3'h3: pf_allow = 8'h08;
         3'h4: pf_allow = 8'h18;
         3'h5: pf_allow = 8'h3c;
         3'h6: pf_allow = 8'h5a;
         default: pf_allow = 8'hff;
      endcase
   end

   always @*
   begin
      pflash_protect_reg_nxt = pflash_protect_reg_r;
      if (wr_pf)
      begin
         if (special_mode)
            pflash_protect_reg_nxt = pf_wr;
         else if (pf_allow[pf_new])
         begin
            pflash_protect_reg_nxt = pf_wr;
            if (!pf_hdis_b)
               pflash_protect_reg_nxt[`FPC_PF_HS_HI:`FPC_PF_HS_LO] =
                  pflash_protect_reg_r[`FPC_PF_HS_HI:`FPC_PF_HS_LO];
            if (!pf_ldis_b)
               pflash_protect_reg_nxt[`FPC_PF_LS_HI:`FPC_PF_LS_LO] =
                  pflash_protect_reg_r[`FPC_PF_LS_HI:`FPC_PF_LS_LO];
         end
      end
      // reset-sequence load overrides a same-cycle write
      if (nvm_load)
      begin
         if (nvm_pflash_fault)
            pflash_protect_reg_nxt = `FPC_PF_FAULT;
         else
            pflash_protect_reg_nxt = nvm_pflash_byte & `FPC_PF_WMASK;
      end
   end

   assign pflash_scenario  = pf_cur;
   assign pflash_full_prot = (pf_cur == 3'h3);

   // ----------------------------------------
   // eeprom protection
   // ----------------------------------------
   wire [7:0]   ee_wr;
   wire         ee_open;
   wire [5:0]   ee_size;
   wire [EAW:0] ee_gran;
   wire [EAW:0] ee_limit;
   wire         ee_hit;

   assign ee_wr   = pwdata[7:0] & `FPC_EE_WMASK;
   assign ee_open = eeprom_protect_reg_r[`FPC_EE_OPEN];
   assign ee_size = eeprom_protect_reg_r[`FPC_EE_SIZE_HI:0];

   always @*
   begin
      eeprom_protect_reg_nxt = eeprom_protect_reg_r;
      if (wr_ee)
      begin
         if (special_mode)
            eeprom_protect_reg_nxt = ee_wr;
         else
         begin
            eeprom_protect_reg_nxt[`FPC_EE_OPEN] = ee_open & ee_wr[`FPC_EE_OPEN];
            if (ee_wr[`FPC_EE_SIZE_HI:0] > ee_size)
               eeprom_protect_reg_nxt[`FPC_EE_SIZE_HI:0] = ee_wr[`FPC_EE_SIZE_HI:0];
         end
      end
      if (nvm_load)
      begin
         if (nvm_eeprom_fault)
            eeprom_protect_reg_nxt = `FPC_EE_FAULT;
         else
            eeprom_protect_reg_nxt = nvm_eeprom_byte & `FPC_EE_WMASK;
      end
   end

   // granules protected from base: size field plus one
   assign ee_gran   = {{(EAW-5){1'b0}}, ee_size} + {{EAW{1'b0}}, 1'b1};
   assign ee_limit  = ee_gran << `FPC_EE_STEP_LOG2;
   assign ee_hit    = ~ee_open & ({1'b0, ee_addr} < ee_limit);
   assign ee_reject = ee_req & (ee_block_erase ? ~ee_open : ee_hit);

   // ----------------------------------------
   // option register
   // ----------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flash_option_reg_r <= `FPC_OPT_RESET;
      else if (nvm_load)
      begin
         if (nvm_option_fault)
            flash_option_reg_r <= `FPC_OPT_FAULT;
         else
            flash_option_reg_r <= nvm_option_byte;
      end
   end

   assign option_bits = flash_option_reg_r;

   // ----------------------------------------
   // status and command launch
   // ----------------------------------------
   wire st_wr;
   wire st_clr_viol;
   wire launch;

   assign st_wr       = wr_acc & hit_status & pstrb[0];
   assign st_clr_viol = st_wr & pwdata[`FPC_ST_PVIOL];
   assign launch      = st_wr & pwdata[`FPC_ST_COMMAND_COMPLETE_FLAG] & command_complete_flag_r;

   // violation flag: set wins over write-one-clear
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pviol_r <= 1'b0;
      else if (ee_reject)
         pviol_r <= 1'b1;
      else if (st_clr_viol)
         pviol_r <= 1'b0;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pflash_protect_reg_r <= `FPC_PF_RESET;
         eeprom_protect_reg_r <= `FPC_EE_RESET;
         command_complete_flag_r               <= 1'b1;
         cmd_launch           <= 1'b0;
         command_index_reg_r  <= 3'h0;
      end
      else
      begin
         pflash_protect_reg_r <= pflash_protect_reg_nxt;
         eeprom_protect_reg_r <= eeprom_protect_reg_nxt;
         cmd_launch           <= launch;
         // completion wins over a launch in the same cycle
         if (cmd_done)
            command_complete_flag_r <= 1'b1;
         else if (launch)
            command_complete_flag_r <= 1'b0;
         if (wr_index && command_complete_flag_r)
            command_index_reg_r <= pwdata[2:0];
      end
   end

   assign command_complete_flag = command_complete_flag_r;
   assign command_word_index    = command_index_reg_r;

   // ----------------------------------------
   // command object array
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `FPC_CMD_WORDS; gi = gi + 1)
      begin : g_word
         wire sel_w;
         assign sel_w = wr_acc && is_cmd && cmd_off == gi && command_complete_flag_r;
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               cmd_word_r[gi] <= 16'h0000;
            else if (res_we && !command_complete_flag_r && res_word == gi)
               cmd_word_r[gi] <= res_data;
            else if (sel_w)
            begin
               if (pstrb[0])
                  cmd_word_r[gi][7:0] <= pwdata[7:0];
               if (pstrb[1])
                  cmd_word_r[gi][15:8] <= pwdata[15:8];
            end
         end
         assign cmd_words[gi*16 +: 16] = cmd_word_r[gi];
      end
   endgenerate

   assign command_code = cmd_word_r[0][15:8];
   assign cmd_address  = {cmd_word_r[0][7:0], cmd_word_r[1]};

   // ----------------------------------------
   // read data, latched in setup cycle
   // ----------------------------------------
   reg [7:0]  rd_byte;
   reg [15:0] rd_word;

   always @*
   begin
      rd_byte = 8'h00;
      rd_word = 16'h0000;
      case (idx)
         `FPC_IDX_CMD_INDEX: rd_byte = {5'h00, command_index_reg_r};
         `FPC_IDX_STATUS:    rd_byte = {command_complete_flag_r, 2'h0, pviol_r, 4'h0};
         `FPC_IDX_PFPROT:    rd_byte = pflash_protect_reg_r;
         `FPC_IDX_EEPROT:    rd_byte = eeprom_protect_reg_r;
         `FPC_IDX_OPTION:    rd_byte = flash_option_reg_r;
         `FPC_IDX_RSV1:      rd_byte = 8'h00;
         default:            rd_byte = 8'h00;
      endcase
      if (is_cmd)
         rd_word = cmd_word_r[cmd_off[2:0]];
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable)
      begin
         if (is_cmd)
            prdata <= {16'h0000, rd_word};
         else
            prdata <= {24'h000000, rd_byte};
      end
   end

endmodule // fpc_flash_prot

/* File: fpc_flash_prot_sva.sv */
`timescale 1ns/10ps
module fpc_flash_prot_sva
(
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // bus
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   // mode and load
   input wire        special_mode,
   input wire        nvm_load,
   input wire        nvm_eeprom_fault,
   input wire        nvm_option_fault,
   input wire [7:0]  nvm_option_byte,
   // command
   input wire        cmd_launch,
   input wire        cmd_done,
   input wire        res_we,
   input wire [95:0] cmd_words,
   input wire [7:0]  command_code,
   input wire [23:0] cmd_address,
   input wire        command_complete_flag,
   // protection
   input wire        ee_req,
   input wire        ee_reject,
   input wire [2:0]  pflash_scenario,
   input wire        pflash_full_prot,
   input wire [7:0]  option_bits
);
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
// faulted load seen, no register write since
reg fault_seen;
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
      fault_seen <= 1'b0;
   else if (nvm_load)
      fault_seen <= nvm_eeprom_fault;
   else if (psel && penable && pwrite)
      fault_seen <= 1'b0;
end
chk_ee_fault: assert property (fault_seen && ee_req |-> ee_reject)
   else $error("eeprom left open after load fault");
chk_opt_load: assert property ($past(nvm_load) |->
   option_bits == ($past(nvm_option_fault) ? 8'hff : $past(nvm_option_byte))) else $error("option load wrong");
chk_opt_hold: assert property (!$past(nvm_load) |-> $stable(option_bits))
   else $error("option bits changed");
chk_full_map: assert property (pflash_full_prot == (pflash_scenario == 3'd3))
   else $error("full protect flag wrong");
chk_pf_open: assert property (!special_mode && !nvm_load && !pflash_scenario[2] |=> !pflash_scenario[2])
   else $error("program flash protection reduced");
chk_launch_clr: assert property (cmd_launch |-> !command_complete_flag)
   else $error("launch with flag set");
chk_done_set: assert property (cmd_done |=> command_complete_flag)
   else $error("flag not set after done");
chk_word_lock: assert property (!command_complete_flag && !res_we |=> $stable(cmd_words))
   else $error("command words changed while locked");
chk_field_map: assert property (command_code == cmd_words[15:8] &&
   cmd_address == {cmd_words[7:0], cmd_words[31:16]}) else $error("command field map wrong");
chk_no_req: assert property (!ee_req |-> !ee_reject)
   else $error("reject without request");
cover property (cmd_launch);
cover property (pflash_full_prot);
cover property (ee_reject);
endmodule // fpc_flash_prot_sva
bind fpc_flash_prot fpc_flash_prot_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .special_mode,
   .nvm_load, .nvm_eeprom_fault,
   .nvm_option_fault, .nvm_option_byte, .cmd_launch, .cmd_done, .res_we, .cmd_words, .command_code,
   .cmd_address, .command_complete_flag, .ee_req, .ee_reject, .pflash_scenario, .pflash_full_prot, .option_bits);

/* File: fpc_flash_prot_tb_top.sv */
`timescale 1ns/10ps
`include "fpc_consts.vh"
module fpc_flash_prot_tb_top;
reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
reg  [7:0]  paddr = 8'h00;
reg  [31:0] pwdata = 32'h0, rd;
reg  [3:0]  pstrb = 4'h0;
reg         special_mode = 1'b0, nvm_load = 1'b0, flt = 1'b0, er;
reg  [7:0]  pf_b = 8'hbf, ee_b = 8'h83, op_b = 8'h5a;
reg         cmd_done = 1'b0, res_we = 1'b0, ee_req = 1'b0, ee_block_erase = 1'b0;
reg  [2:0]  res_word = 3'h0;
reg  [15:0] res_data = 16'h0;
reg  [10:0] ee_addr = 11'h0;
wire        pready, pslverr, cmd_launch, ee_reject, pflash_full_prot, command_complete_flag;
wire [31:0] prdata;
wire [95:0] cmd_words;
wire [7:0]  command_code, option_bits;
wire [23:0] cmd_address;
wire [2:0]  command_word_index, pflash_scenario;
integer     errors = 0, compares = 0, cyc = 0;
fpc_flash_prot DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata,
   .pslverr, .special_mode, .nvm_load, .nvm_pflash_byte(pf_b), .nvm_pflash_fault(flt), .nvm_eeprom_byte(ee_b),
   .nvm_eeprom_fault(flt), .nvm_option_byte(op_b), .nvm_option_fault(flt), .cmd_launch, .cmd_done, .res_we,
   .res_word, .res_data, .cmd_words, .command_code, .cmd_address, .command_word_index, .ee_req, .ee_block_erase,
   .ee_addr, .ee_reject, .pflash_scenario, .pflash_full_prot, .option_bits, .command_complete_flag);
always #25 pclk = ~pclk;
// ----------------------------------------
// bus and compare tasks
// ----------------------------------------
task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
begin
   compares = compares + 1;
   if (g !== e)
   begin
      errors = errors + 1;
      $display("MISMATCH %0s exp %h got %h", nm, e, g);
   end
end
endtask
task apb(input w, input [5:0] i, input [31:0] d, input [3:0] s);
begin
   @(posedge pclk);
   psel <= 1'b1;
   pwrite <= w;
   paddr <= {i, 2'b00};
   pwdata <= d;
   pstrb <= s;
   @(posedge pclk);
   penable <= 1'b1;
   @(posedge pclk);
   while (pready !== 1'b1)
      @(posedge pclk);
   rd = prdata;
   er = pslverr;
   psel <= 1'b0;
   penable <= 1'b0;
end
endtask
task wr(input [5:0] i, input [31:0] d);
   apb(1'b1, i, d, 4'h1);
endtask
task rdc(input [5:0] i, input [31:0] e);
begin
   apb(1'b0, i, 32'h0, 4'h0);
   chk("register", e, rd);
end
endtask
task load(input f);
begin
   @(posedge pclk);
   nvm_load <= 1'b1;
   flt <= f;
   @(posedge pclk);
   nvm_load <= 1'b0;
end
endtask
task ee(input b, input [10:0] a, input e);
begin
   @(posedge pclk);
   ee_req <= 1'b1;
   ee_block_erase <= b;
   ee_addr <= a;
   @(negedge pclk);
   chk("reject", e, ee_reject);
   @(posedge pclk);
   ee_req <= 1'b0;
end
endtask
function [7:0] sc(input [2:0] s);
   sc = {s[2], 1'b0, s[1], 2'b00, s[0], 2'b00};
endfunction
// ----------------------------------------
// scenarios
// ----------------------------------------
task t_load;
begin
   rdc(`FPC_IDX_EEPROT, `FPC_EE_RESET);
   load(1'b0);
   rdc(`FPC_IDX_EEPROT, 32'h83);
   rdc(`FPC_IDX_OPTION, 32'h5a);
   wr(`FPC_IDX_OPTION, 32'h00);
   rdc(`FPC_IDX_OPTION, 32'h5a);
   wr(`FPC_IDX_RSV1, 32'hff);
   rdc(`FPC_IDX_RSV1, 32'h0);
   apb(1'b0, 6'h3f, 32'h0, 4'h0);
   chk("slverr", 1, er);
end
endtask
task t_pf;
   integer f, t;
   reg [7:0] ok;
begin
   for (f = 0; f < 8; f = f + 1)
      for (t = 0; t < 8; t = t + 1)
      begin
         ok = 64'hff5a3c18080c0a0f >> (8 * f);
         special_mode <= 1'b1;
         wr(`FPC_IDX_PFPROT, sc(f));
         special_mode <= 1'b0;
         wr(`FPC_IDX_PFPROT, sc(t));
         rdc(`FPC_IDX_PFPROT, ok[t] ? sc(t) : sc(f));
         chk("scenario", ok[t] ? t : f, pflash_scenario);
      end
   wr(`FPC_IDX_PFPROT, 32'hbf);
   rdc(`FPC_IDX_PFPROT, 32'hbf);
   special_mode <= 1'b1;
   wr(`FPC_IDX_PFPROT, sc(6));
   special_mode <= 1'b0;
   wr(`FPC_IDX_PFPROT, 32'ha3);
   rdc(`FPC_IDX_PFPROT, sc(6));
end
endtask
task t_ee;
begin
   special_mode <= 1'b1;
   wr(`FPC_IDX_EEPROT, 32'h85);
   ee(1'b1, 11'h7ff, 1'b0);
   wr(`FPC_IDX_EEPROT, 32'h05);
   ee(1'b0, 11'd191, 1'b1);
   ee(1'b0, 11'd192, 1'b0);
   ee(1'b1, 11'd0, 1'b1);
   special_mode <= 1'b0;
   wr(`FPC_IDX_EEPROT, 32'h84);
   rdc(`FPC_IDX_EEPROT, 32'h05);
   wr(`FPC_IDX_EEPROT, 32'h86);
   rdc(`FPC_IDX_EEPROT, 32'h06);
   rdc(`FPC_IDX_STATUS, 32'h90);
   wr(`FPC_IDX_STATUS, 32'h10);
   rdc(`FPC_IDX_STATUS, 32'h80);
end
endtask
task t_cmd;
begin
   apb(1'b1, `FPC_IDX_CMD_BASE, 32'h1234, 4'h2);
   apb(1'b1, `FPC_IDX_CMD_BASE, 32'h0056, 4'h1);
   apb(1'b1, `FPC_IDX_CMD_BASE + 6'd1, 32'habcd, 4'h3);
   wr(`FPC_IDX_CMD_INDEX, 32'h1);
   chk("code", 32'h12, command_code);
   chk("address", 32'h56abcd, cmd_address);
   rdc(`FPC_IDX_CMD_BASE, 32'h1256);
   wr(`FPC_IDX_STATUS, 32'h80);
   @(negedge pclk);
   chk("launch", 1, cmd_launch);
   chk("flag", 0, command_complete_flag);
   apb(1'b1, `FPC_IDX_CMD_BASE, 32'hffff, 4'h3);
   wr(`FPC_IDX_CMD_INDEX, 32'h5);
   rdc(`FPC_IDX_CMD_BASE, 32'h1256);
   chk("index", 1, command_word_index);
   @(posedge pclk);
   res_we <= 1'b1;
   res_word <= 3'd2;
   res_data <= 16'hbeef;
   @(posedge pclk);
   res_we <= 1'b0;
   cmd_done <= 1'b1;
   @(posedge pclk);
   cmd_done <= 1'b0;
   rdc(`FPC_IDX_STATUS, 32'h80);
   rdc(`FPC_IDX_CMD_BASE + 6'd2, 32'hbeef);
   chk("result", 32'hbeef, cmd_words[47:32]);
end
endtask
task t_fault;
begin
   load(1'b1);
   rdc(`FPC_IDX_PFPROT, `FPC_PF_FAULT);
   rdc(`FPC_IDX_EEPROT, `FPC_EE_FAULT);
   rdc(`FPC_IDX_OPTION, `FPC_OPT_FAULT);
   ee(1'b0, 11'h7ff, 1'b1);
   chk("full", 1, pflash_full_prot);
end
endtask
task finish_test;
begin
   $display("errors %0d compares %0d", errors, compares);
   if (errors == 0 && compares > 0)
      $display("TEST PASSED");
   else
      $display("TEST FAILED");
   $finish;
end
endtask
always @(posedge pclk)
begin
   cyc = cyc + 1;
   if (cyc == 20000)
   begin
      errors = errors + 1;
      finish_test;
   end
end
initial
begin
   repeat (10) @(posedge pclk);
   presetn <= 1'b1;
   t_load;
   t_pf;
   t_ee;
   t_cmd;
   t_fault;
   finish_test;
end
endmodule // fpc_flash_prot_tb_top
